// file: hdl/icl_top.sv
/*
 Interrupt control logic: flag capture, three-level enable gating, vectoring,
 context save/restore through the shadow bank and sleep wake-up.
 Assumes an AXI4-Lite master for registers and an instruction sequencer that
 reports return-from-interrupt, sleep entry and the fetch it has made.
*/
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module icl_top
   import icl_pkg::*;
#(
   parameter int NUM_PERIPH = ICL_NUM_PERIPH
)
(
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   // AXI4-Lite slave.
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Event sources.
   input  wire logic          ext_pin,
   input  wire logic          timer_event,
   input  wire logic          ioc_event,
   input  wire logic [31:0]   periph_event,
   input  wire logic [31:0]   periph_async,
   // Instruction sequencer.
   input  wire logic          seq_return_from_irq_instr,
   input  wire logic          seq_sleep,
   input  wire logic          seq_fetch_done,
   input  wire icl_ctx_t      live_ctx,
   output logic               irq_flush,
   output logic               irq_push_pc,
   output logic               irq_load_vector,
   output logic [15:0]        irq_vector,
   output logic               irq_restore,
   output icl_ctx_t           restore_ctx,
   output logic               sleeping,
   output logic [1:0]         qphase
);
   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (NUM_PERIPH < 1 || NUM_PERIPH > ICL_NUM_PERIPH)
      $error("NUM_PERIPH must be 1 to 4");

   typedef struct packed
   {
      logic [7:0]  ctrl;
      logic [7:0]  option;
      logic [31:0] pie;
      logic [31:0] pir;
      logic [2:0]  pin_sync;
      logic        pin_edge_seen;
      icl_seq_t    seq;
      logic        asleep;
      logic        aw_ok;
      logic        w_ok;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        flush;
      logic        push;
      logic        load_vec;
      logic        restore;
   } icl_state_t;

   icl_state_t st;
   icl_state_t next_st;
   icl_ctx_if  ctx ();
   logic [1:0] phase;
   logic       cycle_end;
   logic       periph_pending;
   logic       core_pending;
   logic       any_pending;
   logic       wake_req;
   logic       edge_now;
   logic [31:0] rd_word;
   logic       rd_ok;

   icl_qphase u_qphase
   (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .halt      (st.asleep),
      .phase     (phase),
      .cycle_end (cycle_end)
   );

   icl_shadow u_shadow
   (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .ctx     (ctx)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic in_range(input logic [7:0] a, input logic [7:0] base,
                                     input int n);
      return (a >= base) && (int'(a) < int'(base) + 4*n);
   endfunction

   function automatic logic [31:0] periph_mask(input int n);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 8*n; i++)
         m[i] = 1'b1;
      return m;
   endfunction

   // ****************************************************************
   // Pending logic
   // ****************************************************************
   always_comb
   begin
      edge_now = st.option[ICL_EDGE_SEL_BIT] ? (st.pin_sync[2:1] == 2'b01)
                                             : (st.pin_sync[2:1] == 2'b10);
      core_pending = (st.ctrl[ICL_TMR_IE_BIT] && st.ctrl[ICL_TMR_IF_BIT])
                  || (st.ctrl[ICL_EXT_IE_BIT] && st.ctrl[ICL_EXT_IF_BIT])
                  || (st.ctrl[ICL_IOC_IE_BIT] && st.ctrl[ICL_IOC_IF_BIT]);
      periph_pending = st.ctrl[ICL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT]
                    && |(st.pie & st.pir & periph_mask(NUM_PERIPH));
      any_pending = core_pending || periph_pending;
      wake_req = (st.ctrl[ICL_EXT_IE_BIT] && st.ctrl[ICL_EXT_IF_BIT])
              || (st.ctrl[ICL_IOC_IE_BIT] && st.ctrl[ICL_IOC_IF_BIT])
              || (st.ctrl[ICL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT]
                  && |(st.pie & st.pir & periph_async & periph_mask(NUM_PERIPH)));
   end

   // ****************************************************************
   // Register read mux
   // ****************************************************************
   always_comb
   begin
      rd_word = '0;
      rd_ok   = 1'b1;
      if (s_axi_araddr == ICL_CORE_CTRL_OFS)
         rd_word = {24'h000000, st.ctrl};
      else if (s_axi_araddr == ICL_OPTION_OFS)
         rd_word = {24'h000000, st.option};
      else if (s_axi_araddr == ICL_STATE_OFS)
         rd_word = {28'h0000000, st.asleep, 1'b0, st.seq};
      else if (in_range(s_axi_araddr, ICL_PIE_BASE_OFS, NUM_PERIPH))
         rd_word = {24'h000000, st.pie[8*2'(s_axi_araddr[3:2] - 2'h1) +: 8]};
      else if (in_range(s_axi_araddr, ICL_PIR_BASE_OFS, NUM_PERIPH))
         rd_word = {24'h000000, st.pir[8*2'(s_axi_araddr[3:2] - 2'h1) +: 8]};
      else if (in_range(s_axi_araddr, ICL_SHADOW_BASE_OFS, ICL_NUM_SHADOW))
         rd_word = {24'h000000, ctx.shadow[8*(ICL_NUM_SHADOW - 1 -
                    int'((s_axi_araddr - ICL_SHADOW_BASE_OFS) >> 2)) +: 8]};
      else
         rd_ok = 1'b0;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      logic        wr_go;
      logic [7:0]  wb;
      logic [7:0]  a;
      logic [31:0] pir_clr;
      logic [7:0]  ctrl_sw;
      logic        gie_clr;
      logic        gie_set;
      wr_go   = 1'b0;
      wb      = '0;
      a       = '0;
      pir_clr = '1;
      ctrl_sw = st.ctrl;
      gie_clr = 1'b0;
      gie_set = 1'b0;
      next_st = st;
      next_st.flush    = 1'b0;
      next_st.push     = 1'b0;
      next_st.load_vec = 1'b0;
      next_st.restore  = 1'b0;
      ctx.save    = 1'b0;
      ctx.wr      = 1'b0;
      ctx.wr_idx  = '0;
      ctx.wr_data = '0;
      // Pin passes two flip-flops, a third gives the edge.
      next_st.pin_sync = {st.pin_sync[1:0], ext_pin};

      // AXI write channel: address and data accepted in either order.
      if (s_axi_awvalid && !st.aw_ok)
      begin
         next_st.aw_ok  = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_ok)
      begin
         next_st.w_ok  = 1'b1;
         next_st.wdata = s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
      end
      if (st.aw_ok && st.w_ok && !st.bvalid)
      begin
         wr_go = 1'b1;
         a  = st.awaddr;
         wb = st.wdata[7:0];
         next_st.aw_ok  = 1'b0;
         next_st.w_ok   = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = ICL_RESP_OKAY;
      end
      if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;

      if (wr_go)
      begin
         if (a == ICL_CORE_CTRL_OFS)
            ctrl_sw = wb;
         else if (a == ICL_OPTION_OFS)
            next_st.option = wb;
         else if (in_range(a, ICL_PIE_BASE_OFS, NUM_PERIPH))
            next_st.pie[8*2'(a[3:2] - 2'h1) +: 8] = wb;
         else if (in_range(a, ICL_PIR_BASE_OFS, NUM_PERIPH))
         begin
            pir_clr[8*2'(a[3:2] - 2'h1) +: 8] = wb;
         end
         else if (in_range(a, ICL_SHADOW_BASE_OFS, ICL_NUM_SHADOW))
         begin
            ctx.wr      = 1'b1;
            ctx.wr_idx  = 3'((a - ICL_SHADOW_BASE_OFS) >> 2);
            ctx.wr_data = wb;
         end
         else
            next_st.bresp = ICL_RESP_SLVERR;
      end

      // AXI read channel.
      if (s_axi_arvalid && !st.rvalid)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd_word;
         next_st.rresp  = rd_ok ? ICL_RESP_OKAY : ICL_RESP_SLVERR;
      end
      else if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;

      // Software writes may clear flags; a new event in the same cycle wins.
      next_st.pir = (st.pir & pir_clr) | periph_event;
      next_st.ctrl = ctrl_sw;
      // Pin edge is latched across the quarter-four to quarter-one window.
      if (edge_now)
         next_st.pin_edge_seen = 1'b1;
      // Asleep the phase is frozen, so the pin edge is taken at once.
      if ((phase == 2'h0 || st.asleep) && st.pin_edge_seen)
      begin
         next_st.ctrl[ICL_EXT_IF_BIT] = 1'b1;
         next_st.pin_edge_seen = edge_now;
      end
      if (timer_event)
         next_st.ctrl[ICL_TMR_IF_BIT] = 1'b1;
      if (ioc_event)
         next_st.ctrl[ICL_IOC_IF_BIT] = 1'b1;

      // Sequencer. Entry decisions happen at instruction-cycle boundaries only, so
      // latency is the same for one- and two-cycle instructions.
      case (st.seq)
         ICL_RUN:
         begin
            if (seq_sleep)
               next_st.asleep = 1'b1;
            if (st.asleep)
            begin
               if (wake_req)
               begin
                  next_st.asleep = 1'b0;
                  next_st.seq = ICL_WAKE;
               end
            end
            else if (cycle_end && st.ctrl[ICL_GIE_BIT] && any_pending)
            begin
               next_st.seq   = ICL_ENTRY;
               next_st.flush = 1'b1;
               gie_clr       = 1'b1;
            end
         end
         ICL_ENTRY:
         begin
            if (cycle_end)
            begin
               next_st.push     = 1'b1;
               next_st.load_vec = 1'b1;
               ctx.save         = 1'b1;
               next_st.seq      = ICL_ISR;
            end
         end
         ICL_ISR:
         begin
            if (seq_return_from_irq_instr)
            begin
               next_st.restore = 1'b1;
               gie_set         = 1'b1;
               next_st.seq     = ICL_RUN;
            end
         end
         ICL_WAKE:
         begin
            // The fetch pulse need not meet a cycle end; RUN waits for one.
            if (seq_fetch_done)
               next_st.seq = ICL_RUN;
         end
         default:
            next_st.seq = ICL_RUN;
      endcase
      if (gie_clr)
         next_st.ctrl[ICL_GIE_BIT] = 1'b0;
      if (gie_set)
         next_st.ctrl[ICL_GIE_BIT] = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st        <= '0;
         st.ctrl   <= ICL_CTRL_RESET;
         st.option <= ICL_OPTION_RESET;
         st.seq    <= ICL_RUN;
      end
      else
         st <= next_st;
   end

   assign ctx.live    = live_ctx;
   assign ctx.restore = st.restore;

   // ****************************************************************
   // Outputs
   // ****************************************************************
   icl_ctx_t restore_q;
   logic [1:0] phase_q;
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         restore_q <= '0;
         phase_q   <= '0;
      end
      else
      begin
         restore_q <= ctx.shadow;
         phase_q   <= phase;
      end
   end

   assign s_axi_awready   = !st.aw_ok;
   assign s_axi_wready    = !st.w_ok;
   assign s_axi_bvalid    = st.bvalid;
   assign s_axi_bresp     = st.bresp;
   assign s_axi_arready   = !st.rvalid;
   assign s_axi_rvalid    = st.rvalid;
   assign s_axi_rdata     = st.rdata;
   assign s_axi_rresp     = st.rresp;
   assign irq_flush       = st.flush;
   assign irq_push_pc     = st.push;
   assign irq_load_vector = st.load_vec;
   assign irq_vector      = ICL_IRQ_VECTOR;
   assign irq_restore     = st.restore;
   assign restore_ctx     = restore_q;
   assign sleeping        = st.asleep;
   assign qphase          = phase_q;
endmodule // icl_top

// file: inc/icl_pkg.sv
/*
 Package of the interrupt control logic: register offsets, field positions,
 reset values, timing counts and shared types.
 Assumes a 40 MHz reference clock and a 32-bit AXI4-Lite register bus.
*/
package icl_pkg;
   // ****************************************************************
   // Register map (byte addresses, one aligned word each)
   // ****************************************************************
   localparam logic [7:0] ICL_CORE_CTRL_OFS   = 8'h00;
   localparam logic [7:0] ICL_PIE_BASE_OFS    = 8'h04;
   localparam logic [7:0] ICL_PIR_BASE_OFS    = 8'h14;
   localparam logic [7:0] ICL_OPTION_OFS      = 8'h24;
   localparam logic [7:0] ICL_SHADOW_BASE_OFS = 8'h28;
   localparam logic [7:0] ICL_STATE_OFS       = 8'h44;
   localparam int         ICL_NUM_PERIPH      = 4;
   localparam int         ICL_NUM_SHADOW      = 7;
   // ****************************************************************
   // Core control and option register fields
   // ****************************************************************
   localparam int ICL_GIE_BIT      = 7;
   localparam int ICL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT     = 6;
   localparam int ICL_TMR_IE_BIT   = 5;
   localparam int ICL_EXT_IE_BIT   = 4;
   localparam int ICL_IOC_IE_BIT   = 3;
   localparam int ICL_TMR_IF_BIT   = 2;
   localparam int ICL_EXT_IF_BIT   = 1;
   localparam int ICL_IOC_IF_BIT   = 0;
   localparam int ICL_EDGE_SEL_BIT = 6;
   localparam logic [7:0] ICL_CTRL_RESET   = 8'h00;
   localparam logic [7:0] ICL_OPTION_RESET = 8'h40;
   // Status bits that are not part of the saved context.
   localparam logic [7:0] ICL_STATUS_KEEP  = 8'h18;
   localparam logic [15:0] ICL_IRQ_VECTOR  = 16'h0004;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int ICL_CLK_MHZ     = 40;
   localparam int ICL_QPHASES     = 4;
   localparam logic [1:0] ICL_RESP_OKAY   = 2'b00;
   localparam logic [1:0] ICL_RESP_SLVERR = 2'b10;

   typedef enum logic [1:0]
   {
      ICL_RUN   = 2'b00,
      ICL_ENTRY = 2'b01,
      ICL_ISR   = 2'b10,
      ICL_WAKE  = 2'b11
   } icl_seq_t;

   typedef struct packed
   {
      logic [7:0] w;
      logic [7:0] status;
      logic [7:0] bank_select_reg;
      logic [7:0] fsr0l;
      logic [7:0] fsr0h;
      logic [7:0] fsr1l;
      logic [7:0] pc_high_latch;
   } icl_ctx_t;
endpackage

// file: inc/icl_ctx_if.sv
/*
 Interface carrying context save/restore between the top and the shadow bank.
 Assumes one clock domain.
*/
`timescale 1ns/100ps
interface icl_ctx_if;
   import icl_pkg::*;
   logic       save;
   logic       restore;
   icl_ctx_t   live;
   icl_ctx_t   shadow;
   logic       wr;
   logic [2:0] wr_idx;
   logic [7:0] wr_data;
   modport ctl (output save, output restore, output live, output wr, output wr_idx,
                output wr_data, input shadow);
   modport bank (input save, input restore, input live, input wr, input wr_idx,
                 input wr_data, output shadow);
endinterface

// file: hdl/icl_shadow.sv
/*
 Shadow register bank: captures the live context on interrupt entry and can be
 rewritten by software so that a changed value is restored on return.
 Assumes save and software writes never coincide with a restore.
*/
`timescale 1ns/100ps
module icl_shadow
   import icl_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rstn,
   icl_ctx_if.bank   ctx
);
   typedef struct packed
   {
      icl_ctx_t sh;
   } icl_sh_state_t;
   icl_sh_state_t st;
   icl_sh_state_t next_st;

   always_comb
   begin
      next_st = st;
      if (ctx.save)
      begin
         next_st.sh = ctx.live;
         next_st.sh.status = ctx.live.status & ~ICL_STATUS_KEEP;
      end
      else if (ctx.wr && (int'(ctx.wr_idx) < ICL_NUM_SHADOW))
         next_st.sh[8*(ICL_NUM_SHADOW-1-int'(ctx.wr_idx)) +: 8] = ctx.wr_data;
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         st <= '0;
      else
         st <= next_st;
   end

   assign ctx.shadow = st.sh;
endmodule // icl_shadow

// file: hdl/icl_qphase.sv
/*
 Quarter-phase generator: divides the reference clock into instruction cycles
 of four quarter phases. Assumes the reference clock is the system clock.
*/
`timescale 1ns/100ps
module icl_qphase
   import icl_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       halt,
   output logic [1:0]      phase,
   output logic            cycle_end
);
   typedef struct packed
   {
      logic [1:0] q;
   } icl_qp_state_t;
   icl_qp_state_t st;
   icl_qp_state_t next_st;

   always_comb
   begin
      next_st = st;
      // While asleep the phase stands still, as the system clock would.
      if (!halt)
         next_st.q = st.q + 2'h1;
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         st <= '0;
      else
         st <= next_st;
   end

   assign phase     = st.q;
   assign cycle_end = (st.q == 2'h3) && !halt;
endmodule // icl_qphase

// file: verification/icl_top_sva.sv
/*
 Checker on the top ports of the interrupt control logic.
 Assumes it is bound to the top module and sees its clock and reset.
*/
`timescale 1ns/100ps
module icl_top_sva
   import icl_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        irq_flush,
   input wire logic        irq_push_pc,
   input wire logic        irq_load_vector,
   input wire logic [15:0] irq_vector,
   input wire logic        irq_restore,
   input wire icl_ctx_t    restore_ctx,
   input wire logic        sleeping
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // The flush and the vector load are one instruction cycle apart.
   sequence s_quiet;
      (!irq_flush && !irq_load_vector) [*3];
   endsequence
   property p_entry; irq_flush |=> s_quiet ##1 irq_load_vector; endproperty
   a_entry: assert property (p_entry)
      else $error("vector load not four cycles after flush");
   property p_push; irq_load_vector |-> irq_push_pc && irq_vector == ICL_IRQ_VECTOR; endproperty
   a_push: assert property (p_push)
      else $error("vector load without push or wrong vector");
   property p_sleep; sleeping |-> !irq_flush && !irq_load_vector; endproperty
   a_sleep: assert property (p_sleep)
      else $error("entry while asleep");
   property p_mask; irq_restore |-> (restore_ctx.status & ICL_STATUS_KEEP) == 8'h00; endproperty
   a_mask: assert property (p_mask)
      else $error("restored status carries excluded bits");
   property p_ret; irq_restore |-> !irq_flush && !irq_load_vector; endproperty
   a_ret: assert property (p_ret)
      else $error("restore overlaps entry");
   property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bdone: assert property (p_bdone)
      else $error("write response repeated");
   property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rdone: assert property (p_rdone)
      else $error("read response repeated");
   property p_rzero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
   a_rzero: assert property (p_rzero)
      else $error("upper read bits not zero");
endmodule // icl_top_sva

// file: verification/icl_seq_model.sv
/*
 Sequencer model: pulses sleep and return on request, reports the fetch
 after a wake-up and counts vector loads. Assumes the top module beside it.
*/
`timescale 1ns/100ps
module icl_seq_model
   import icl_pkg::*;
(
   input  wire logic  ref_clk,
   input  wire logic  rstn,
   input  wire logic  go_sleep,
   input  wire logic  go_ret,
   input  wire logic  slow,
   input  wire logic  irq_load_vector,
   input  wire logic  sleeping,
   output logic       seq_sleep,
   output logic       seq_return_from_irq_instr,
   output logic       seq_fetch_done,
   output icl_ctx_t   live_ctx,
   output logic [7:0] vec_cnt,
   output logic       bad
);
   logic       was_asleep;
   logic [2:0] wait_cnt;
   // ****************************************************************
   // Sequencer
   // ****************************************************************
   // A slow fetch after wake-up shows whether the vector waits for it.
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         {seq_sleep, seq_return_from_irq_instr, seq_fetch_done, was_asleep, bad} <= '0;
         {wait_cnt, vec_cnt} <= '0;
         live_ctx <= '0;
      end
      else
      begin
         seq_sleep <= go_sleep;
         seq_return_from_irq_instr <= go_ret;
         was_asleep <= sleeping;
         live_ctx <= ~live_ctx;
         seq_fetch_done <= wait_cnt == 3'h1;
         if (was_asleep && !sleeping)
            wait_cnt <= slow ? 3'h4 : 3'h1;
         else if (wait_cnt != 3'h0)
            wait_cnt <= wait_cnt - 3'h1;
         if (irq_load_vector)
            vec_cnt <= vec_cnt + 8'h01;
         if (irq_load_vector && wait_cnt != 3'h0)
            bad <= 1'b1;
      end
endmodule // icl_seq_model

// file: verification/tb_icl_top.sv
/*
 Testbench of the interrupt control logic: AXI4-Lite tasks, event pulses.
 Assumes the sequencer model and the bound checker.
*/
`timescale 1ns/100ps
module tb_icl_top
   import icl_pkg::*;
   ;
   localparam logic [7:0] ctl = ICL_CORE_CTRL_OFS;
   localparam logic [7:0] periph_enable_reg_1 = ICL_PIE_BASE_OFS;
   localparam logic [7:0] periph_request_reg_1 = ICL_PIR_BASE_OFS;
   localparam logic [7:0] periph_request_reg_2 = ICL_PIR_BASE_OFS + 8'h04;
   logic        ref_clk, rstn, awv, wv, bry, arv, rry, pin, gs, gr, slow, tev, iev;
   logic        awr, wrdy, bv, arr, rv, fl, push, ldv, rest, slp, s_sl, s_rt, fd, bad;
   logic [1:0]  br, rr, qph;
   logic [7:0]  awa, ara, vcnt, gw;
   logic [15:0] vec;
   logic [31:0] wd, rdd, pev, pas;
   icl_ctx_t    live, rctx;
   int          mismatches, checks_done;
   icl_top icl_top_inst (
      .ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .ext_pin(pin),
      .timer_event(tev), .ioc_event(iev), .periph_event(pev), .periph_async(pas),
      .seq_return_from_irq_instr(s_rt), .seq_sleep(s_sl), .seq_fetch_done(fd), .live_ctx(live),
      .irq_flush(fl), .irq_push_pc(push), .irq_load_vector(ldv), .irq_vector(vec),
      .irq_restore(rest), .restore_ctx(rctx), .sleeping(slp), .qphase(qph));
   icl_seq_model icl_seq_model_inst (
      .ref_clk(ref_clk), .rstn(rstn), .go_sleep(gs), .go_ret(gr), .slow(slow),
      .irq_load_vector(ldv), .sleeping(slp), .seq_sleep(s_sl), .seq_return_from_irq_instr(s_rt),
      .seq_fetch_done(fd), .live_ctx(live), .vec_cnt(vcnt), .bad(bad));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (rest)
         gw <= rctx.w;
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic chkr(input logic [7:0] a, input logic [1:0] g);
      chk({30'h0, a > ICL_STATE_OFS ? ICL_RESP_SLVERR : ICL_RESP_OKAY}, {30'h0, g});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      {awa, wd, awv, wv} <= {a, d, 2'b11};
      while (!(ta && tw))
      begin
         @(posedge ref_clk);
         ta = ta || awr;
         tw = tw || wrdy;
         if (ta)
            awv <= 1'b0;
         if (tw)
            wv <= 1'b0;
      end
      do
         @(posedge ref_clk);
      while (bv !== 1'b1);
      chkr(a, br);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      {ara, arv} <= {a, 1'b1};
      do
         @(posedge ref_clk);
      while (arr !== 1'b1);
      arv <= 1'b0;
      do
         @(posedge ref_clk);
      while (rv !== 1'b1);
      chkr(a, rr);
      chk(e, rdd);
   endtask
   task automatic ev(input logic [1:0] t, input logic [31:0] p);
      @(posedge ref_clk);
      {iev, tev, pev} <= {t, p};
      @(posedge ref_clk);
      {iev, tev, pev} <= '0;
   endtask
   task automatic seqp(input logic s);
      @(posedge ref_clk);
      {gs, gr} <= {s, !s};
      @(posedge ref_clk);
      {gs, gr} <= 2'b00;
      repeat (4) @(posedge ref_clk);
   endtask
   // Twenty cycles is five instruction cycles, the longest latency allowed.
   task automatic after(input int n, input logic [7:0] e);
      repeat (n) @(posedge ref_clk);
      chk({24'h0, e}, {24'h0, vcnt});
   endtask
   task automatic give_verdict;
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ****************************************************************
   // Sequences
   // ****************************************************************
   initial
   begin
      repeat (8000) @(posedge ref_clk);
      mismatches++;
      give_verdict;
   end
   initial
   begin
      ref_clk = 1'b0;
      {rstn, awv, wv, arv, pin, gs, gr, slow, tev, iev} = '0;
      {bry, rry} = 2'b11;
      {awa, ara, wd, pev, pas} = '0;
      mismatches = 0;
      checks_done = 0;
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(ctl, 32'h00);
      rd(ICL_OPTION_OFS, 32'h40);
      ev(2'b11, 32'h200);
      rd(ctl, 32'h05);
      rd(periph_request_reg_2, 32'h02);
      wr(ctl, 32'h00);
      wr(periph_request_reg_2, 32'hfd);
      rd(periph_request_reg_2, 32'h00);
      wr(ctl, 32'h80);
      ev(2'b01, 32'h0);
      after(20, 8'h00);
      rd(ctl, 32'h84);
      wr(ctl, 32'ha4);
      after(40, 8'h01);
      rd(ctl, 32'h24);
      wr(ICL_SHADOW_BASE_OFS, 32'h5a);
      rd(ICL_SHADOW_BASE_OFS, 32'h5a);
      seqp(1'b0);
      after(40, 8'h02);
      chk(32'h5a, {24'h0, gw});
      wr(ctl, 32'h20);
      seqp(1'b0);
      after(40, 8'h02);
      rd(ctl, 32'ha0);
      wr(ctl, 32'h80);
      wr(periph_enable_reg_1, 32'h01);
      ev(2'b00, 32'h1);
      after(20, 8'h02);
      wr(ctl, 32'hc0);
      after(40, 8'h03);
      wr(periph_request_reg_1, 32'hfe);
      seqp(1'b0);
      after(40, 8'h03);
      wr(ctl, 32'h10);
      pin <= 1'b1;
      after(20, 8'h03);
      rd(ctl, 32'h12);
      wr(ctl, 32'h10);
      wr(ICL_OPTION_OFS, 32'h00);
      pin <= 1'b0;
      after(20, 8'h03);
      rd(ctl, 32'h12);
      wr(ctl, 32'h10);
      pin <= 1'b1;
      after(20, 8'h03);
      rd(ctl, 32'h10);
      wr(ctl, 32'h40);
      wr(periph_enable_reg_1, 32'h03);
      pas <= 32'h1;
      seqp(1'b1);
      ev(2'b00, 32'h2);
      after(20, 8'h03);
      chk(32'h1, {31'h0, slp});
      ev(2'b00, 32'h1);
      after(20, 8'h03);
      chk(32'h0, {30'h0, slp, bad});
      wr(periph_request_reg_1, 32'hfc);
      wr(ctl, 32'hc0);
      slow <= 1'b1;
      seqp(1'b1);
      ev(2'b00, 32'h1);
      after(40, 8'h04);
      chk(32'h0, {31'h0, bad});
      rd(8'h80, 32'h0);
      wr(8'h80, 32'h0);
      give_verdict;
   end
endmodule // tb_icl_top
bind icl_top icl_top_sva icl_top_sva_inst (
   .ref_clk(ref_clk), .rstn(rstn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .irq_flush(irq_flush), .irq_push_pc(irq_push_pc),
   .irq_load_vector(irq_load_vector), .irq_vector(irq_vector), .irq_restore(irq_restore),
   .restore_ctx(restore_ctx), .sleeping(sleeping));
